// [logic/optmod_host_end.sv]
// Host board controller end: drives the disable line and paces management bytes.
// Assumes the module answers each byte request one cycle after it.
module optmod_host_end
  import optmod_pkg::*;
#(
  parameter int unsigned SERIAL_READY_CNT = SERIAL_READY_CYCLES,
  parameter int unsigned WRITE_CYCLE_CNT = WRITE_CYCLE_CYCLES,
  parameter int unsigned BYTE_CNT = SERIAL_BYTE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  optmod_link_if.host_end link,
  input wire logic laser_off_i,
  input wire logic fault_reset_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_page_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_last_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic rsp_ok_o,
  output logic [7:0] rsp_data_o,
  output logic fault_o,
  output logic signal_lost_o
);

  typedef enum logic {H_IDLE, H_WAIT} host_state_e;

  host_state_e state_q, state_d;
  logic [31:0] gap_q, gap_d;
  logic [31:0] hold_q, hold_d;
  logic dis_q, dis_d;
  logic req_q, req_d;
  logic we_q, we_d;
  logic page_q, page_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic last_q, last_d;
  logic ready_q, ready_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_ok_q, rsp_ok_d;
  logic [7:0] rsp_data_q, rsp_data_d;
  logic fault_q, los_q;

  // ----------------------------------------
  // Disable line
  // ----------------------------------------
  always_comb begin
    hold_d = (hold_q != 32'h0000_0000) ? hold_q - 32'h0000_0001 : hold_q;
    if (fault_reset_i && hold_q == 32'h0000_0000) begin
      hold_d = 32'(RESET_HOLD_CYCLES);
    end
    dis_d = laser_off_i | (hold_d != 32'h0000_0000);
  end

  // ----------------------------------------
  // Byte sequencer
  // ----------------------------------------
  // Spacing per byte stands in for the serial clock limit
  always_comb begin
    state_d = state_q;
    gap_d = (gap_q != 32'h0000_0000) ? gap_q - 32'h0000_0001 : gap_q;
    req_d = 1'b0;
    we_d = we_q;
    page_d = page_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    last_d = last_q;
    rsp_valid_d = 1'b0;
    rsp_ok_d = rsp_ok_q;
    rsp_data_d = rsp_data_q;
    case (state_q)
      H_IDLE: begin
        if (cmd_valid_i && ready_q) begin
          req_d = 1'b1;
          we_d = cmd_write_i;
          page_d = cmd_page_i;
          addr_d = cmd_addr_i;
          wdata_d = cmd_data_i;
          last_d = cmd_last_i;
          gap_d = 32'(BYTE_CNT);
          state_d = H_WAIT;
        end
      end
      H_WAIT: begin
        if (link.mgmt_ack) begin
          rsp_valid_d = 1'b1;
          rsp_ok_d = link.mgmt_ok;
          rsp_data_d = link.mgmt_rdata;
          if (we_q && last_q && gap_q < 32'(WRITE_CYCLE_CNT)) begin
            gap_d = 32'(WRITE_CYCLE_CNT);
          end
          state_d = H_IDLE;
        end
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
    ready_d = (state_d == H_IDLE) && (gap_d == 32'h0000_0000) && !(cmd_valid_i && ready_q);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= H_IDLE;
      gap_q <= 32'(SERIAL_READY_CNT);
      hold_q <= 32'h0000_0000;
      dis_q <= 1'b0;
      req_q <= 1'b0;
      we_q <= 1'b0;
      page_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      last_q <= 1'b0;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_ok_q <= 1'b0;
      rsp_data_q <= 8'h00;
      fault_q <= 1'b0;
      los_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gap_q <= gap_d;
      hold_q <= hold_d;
      dis_q <= dis_d;
      req_q <= req_d;
      we_q <= we_d;
      page_q <= page_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      last_q <= last_d;
      ready_q <= ready_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_ok_q <= rsp_ok_d;
      rsp_data_q <= rsp_data_d;
      fault_q <= link.tx_fault;
      los_q <= link.rx_signal_lost;
    end
  end

  assign link.laser_disable = dis_q;
  assign link.mgmt_req = req_q;
  assign link.mgmt_we = we_q;
  assign link.mgmt_page = page_q;
  assign link.mgmt_addr = addr_q;
  assign link.mgmt_wdata = wdata_q;
  assign link.mgmt_last = last_q;
  assign cmd_ready_o = ready_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_ok_o = rsp_ok_q;
  assign rsp_data_o = rsp_data_q;
  assign fault_o = fault_q;
  assign signal_lost_o = los_q;

endmodule

// [logic/optmod_link_if.sv]
// Link between the host board controller and the optical module.
// Assumes both ends run on the same clock; management bytes are abstracted.
interface optmod_link_if;
  logic laser_disable;
  logic tx_fault;
  logic rx_signal_lost;
  logic mgmt_req;
  logic mgmt_we;
  logic mgmt_page;
  logic [7:0] mgmt_addr;
  logic [7:0] mgmt_wdata;
  logic mgmt_last;
  logic mgmt_ack;
  logic mgmt_ok;
  logic [7:0] mgmt_rdata;

  modport module_end (
    input laser_disable, mgmt_req, mgmt_we, mgmt_page, mgmt_addr, mgmt_wdata, mgmt_last,
    output tx_fault, rx_signal_lost, mgmt_ack, mgmt_ok, mgmt_rdata
  );

  modport host_end (
    output laser_disable, mgmt_req, mgmt_we, mgmt_page, mgmt_addr, mgmt_wdata, mgmt_last,
    input tx_fault, rx_signal_lost, mgmt_ack, mgmt_ok, mgmt_rdata
  );
endinterface

// [logic/optmod_module_end.sv]
// Optical module end: laser enable, fault latch, signal loss and management bytes.
// Assumes the host paces bytes; bytes inside the write cycle time or power-on wait are refused.
module optmod_module_end
  import optmod_pkg::*;
#(
  parameter int unsigned INIT_CNT = INIT_CYCLES,
  parameter int unsigned DATA_READY_CNT = DATA_READY_CYCLES,
  parameter int unsigned SERIAL_READY_CNT = SERIAL_READY_CYCLES,
  parameter int unsigned WRITE_CYCLE_CNT = WRITE_CYCLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  optmod_link_if.module_end link,
  input wire logic laser_fault_i,
  input wire logic signal_ok_i,
  input wire logic monitor_ok_i,
  output logic laser_on_o,
  output logic init_done_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] por_cnt_q, por_cnt_d;
  logic [31:0] init_cnt_q, init_cnt_d;
  logic [31:0] hold_cnt_q, hold_cnt_d;
  logic [31:0] busy_cnt_q, busy_cnt_d;
  logic dis_prev_q, dis_prev_d;
  logic fault_q, fault_d;
  logic los_q, los_d;
  logic soft_dis_q, soft_dis_d;
  logic ready_q, ready_d;
  logic laser_on_q, laser_on_d;
  logic init_done_q, init_done_d;
  logic ack_q, ack_d;
  logic ok_q, ok_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] scratch_q [SCRATCH_DEPTH];
  logic [7:0] scratch_d [SCRATCH_DEPTH];

  logic dis_fall;
  logic bus_open;
  logic accept;
  logic [7:0] status_byte;
  logic in_scratch;
  logic [2:0] scratch_idx;
  logic [7:0] scratch_off;

  assign dis_fall = dis_prev_q & ~link.laser_disable;
  assign bus_open = por_cnt_q >= SERIAL_READY_CNT;
  assign accept = link.mgmt_req & bus_open & (busy_cnt_q == 32'h0000_0000);
  assign scratch_off = link.mgmt_addr - SCRATCH_BASE_ADDR;
  assign in_scratch = (link.mgmt_page == PAGE_DIAG) && (link.mgmt_addr >= SCRATCH_BASE_ADDR)
    && (scratch_off < 8'(SCRATCH_DEPTH));
  assign scratch_idx = scratch_off[2:0];

  always_comb begin
    status_byte = 8'h00;
    status_byte[HW_DISABLE_BIT] = link.laser_disable;
    status_byte[SOFT_DISABLE_BIT] = soft_dis_q;
    status_byte[FAULT_BIT] = fault_q;
    status_byte[SIGNAL_LOST_BIT] = los_q;
    status_byte[DATA_READY_BIT] = ready_q;
  end

  // ----------------------------------------
  // Power-on timing, init and fault latch
  // ----------------------------------------
  always_comb begin
    por_cnt_d = por_cnt_q;
    if (por_cnt_q != 32'hFFFF_FFFF) begin
      por_cnt_d = por_cnt_q + 32'h0000_0001;
    end
    dis_prev_d = link.laser_disable;
    hold_cnt_d = 32'h0000_0000;
    if (link.laser_disable) begin
      hold_cnt_d = (hold_cnt_q == 32'hFFFF_FFFF) ? hold_cnt_q : hold_cnt_q + 32'h0000_0001;
    end
    // Init restarts on every release of the disable line
    init_cnt_d = init_cnt_q;
    init_done_d = init_done_q;
    if (dis_fall) begin
      init_cnt_d = 32'(INIT_CNT);
      init_done_d = 1'b0;
    end else if (init_cnt_q > 32'h0000_0001) begin
      init_cnt_d = init_cnt_q - 32'h0000_0001;
    end else begin
      init_cnt_d = 32'h0000_0000;
      init_done_d = 1'b1;
    end
    // Latched until a long enough disable hold ends; a new fault wins over the clear
    fault_d = fault_q;
    if (dis_fall && hold_cnt_q >= 32'(RESET_HOLD_CYCLES)) begin
      fault_d = 1'b0;
    end
    if (laser_fault_i) begin
      fault_d = 1'b1;
    end
    los_d = ~signal_ok_i;
    ready_d = monitor_ok_i && (por_cnt_q >= 32'(DATA_READY_CNT));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      por_cnt_q <= 32'h0000_0000;
      dis_prev_q <= 1'b0;
      hold_cnt_q <= 32'h0000_0000;
      init_cnt_q <= 32'(INIT_CNT);
      init_done_q <= 1'b0;
      fault_q <= 1'b0;
      los_q <= 1'b1;
      ready_q <= 1'b0;
    end else begin
      por_cnt_q <= por_cnt_d;
      dis_prev_q <= dis_prev_d;
      hold_cnt_q <= hold_cnt_d;
      init_cnt_q <= init_cnt_d;
      init_done_q <= init_done_d;
      fault_q <= fault_d;
      los_q <= los_d;
      ready_q <= ready_d;
    end
  end

  // ----------------------------------------
  // Laser drive
  // ----------------------------------------
  // Registered one cycle behind its terms; a disable line release with init done turns it on for one cycle, then it waits for the restarted init to finish
  always_comb begin
    laser_on_d = init_done_q & ~link.laser_disable & ~soft_dis_q & ~fault_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      laser_on_q <= 1'b0;
    end else begin
      laser_on_q <= laser_on_d;
    end
  end

  // ----------------------------------------
  // Management byte access
  // ----------------------------------------
  // Refused bytes are still answered, with ok low, so the host never hangs
  always_comb begin
    ack_d = link.mgmt_req;
    ok_d = accept;
    rdata_d = UNMAPPED_DATA;
    soft_dis_d = soft_dis_q;
    busy_cnt_d = (busy_cnt_q != 32'h0000_0000) ? busy_cnt_q - 32'h0000_0001 : busy_cnt_q;
    if (accept) begin
      if (link.mgmt_page == PAGE_DIAG && link.mgmt_addr == CTRL_STATUS_ADDR) begin
        rdata_d = status_byte;
        if (link.mgmt_we) begin
          soft_dis_d = link.mgmt_wdata[SOFT_DISABLE_BIT];
        end
      end else if (in_scratch) begin
        rdata_d = scratch_q[scratch_idx];
      end
      if (link.mgmt_we && link.mgmt_last) begin
        busy_cnt_d = 32'(WRITE_CYCLE_CNT);
      end
    end
  end

  for (genvar i = 0; i < SCRATCH_DEPTH; i++) begin : g_scratch
    always_comb begin
      scratch_d[i] = scratch_q[i];
      if (accept && link.mgmt_we && in_scratch && scratch_idx == 3'(i)) begin
        scratch_d[i] = link.mgmt_wdata;
      end
    end

    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        scratch_q[i] <= 8'h00;
      end else begin
        scratch_q[i] <= scratch_d[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      ok_q <= 1'b0;
      rdata_q <= 8'h00;
      soft_dis_q <= 1'b0;
      busy_cnt_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      ok_q <= ok_d;
      rdata_q <= rdata_d;
      soft_dis_q <= soft_dis_d;
      busy_cnt_q <= busy_cnt_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.tx_fault = fault_q;
  assign link.rx_signal_lost = los_q;
  assign link.mgmt_ack = ack_q;
  assign link.mgmt_ok = ok_q;
  assign link.mgmt_rdata = rdata_q;
  assign laser_on_o = laser_on_q;
  assign init_done_o = init_done_q;

endmodule

// [logic/optmod_pkg.sv]
// Shared constants for the optical module control and status link.
// Assumes a single 250 MHz clock shared by both ends of the link.
package optmod_pkg;

  // ----------------------------------------
  // Clock
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;

  // ----------------------------------------
  // Times as printed, and derived cycle counts
  // ----------------------------------------
  localparam int unsigned T_RESET_HOLD_US = 10;
  localparam int unsigned T_INIT_MS = 300;
  localparam int unsigned T_DATA_READY_MS = 1000;
  localparam int unsigned T_SERIAL_READY_MS = 300;
  localparam int unsigned T_WRITE_CYCLE_MS = 10;
  localparam int unsigned F_SERIAL_CLOCK_KHZ = 400;
  localparam int unsigned SERIAL_BITS_PER_BYTE = 9;

  // Least times round up, longest times round down
  localparam int unsigned RESET_HOLD_CYCLES =
    (T_RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_CYCLES = (T_INIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned DATA_READY_CYCLES = (T_DATA_READY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned SERIAL_READY_CYCLES = (T_SERIAL_READY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYCLE_CYCLES = (T_WRITE_CYCLE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned SERIAL_BYTE_NS =
    (SERIAL_BITS_PER_BYTE * 1000000 + F_SERIAL_CLOCK_KHZ - 1) / F_SERIAL_CLOCK_KHZ;
  localparam int unsigned SERIAL_BYTE_CYCLES =
    (SERIAL_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Management address map
  // ----------------------------------------
  localparam logic PAGE_ID = 1'b0;
  localparam logic PAGE_DIAG = 1'b1;
  localparam logic [7:0] CTRL_STATUS_ADDR = 8'h6E;
  localparam logic [7:0] SCRATCH_BASE_ADDR = 8'h80;
  localparam int unsigned SCRATCH_DEPTH = 8;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // Control and status byte fields
  localparam int unsigned HW_DISABLE_BIT = 7;
  localparam int unsigned SOFT_DISABLE_BIT = 6;
  localparam int unsigned FAULT_BIT = 2;
  localparam int unsigned SIGNAL_LOST_BIT = 1;
  localparam int unsigned DATA_READY_BIT = 0;

endpackage

// [testbench/optmod_link_monitor.sv]
// Checker for the link between the host end and the module end.
// Assumes one clock and a synchronous active-low reset shared by both ends.
module optmod_link_monitor
  import optmod_pkg::*;
#(
  parameter int unsigned SERIAL_READY_CNT = SERIAL_READY_CYCLES,
  parameter int unsigned WRITE_CYCLE_CNT = WRITE_CYCLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic laser_disable,
  input wire logic tx_fault,
  input wire logic rx_signal_lost,
  input wire logic mgmt_req,
  input wire logic mgmt_we,
  input wire logic mgmt_page,
  input wire logic [7:0] mgmt_addr,
  input wire logic mgmt_last,
  input wire logic mgmt_ack,
  input wire logic mgmt_ok,
  input wire logic [7:0] mgmt_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Saturating, so a long run never wraps into a false short gap
  logic [15:0] por_q;
  logic [15:0] gap_q;
  logic [15:0] hold_q;
  logic dis_q;
  logic wr_last_q;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      por_q <= 16'h0000;
      gap_q <= 16'hFFFF;
      hold_q <= 16'h0000;
      dis_q <= 1'b0;
      wr_last_q <= 1'b0;
    end else begin
      if (por_q != 16'hFFFF) por_q <= por_q + 16'h0001;
      wr_last_q <= mgmt_req & mgmt_we & mgmt_last;
      if (mgmt_ack && mgmt_ok && wr_last_q) gap_q <= 16'h0000;
      else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
      dis_q <= laser_disable;
      if (laser_disable && !dis_q) hold_q <= 16'h0001;
      else if (laser_disable && hold_q != 16'hFFFF) hold_q <= hold_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence status_rd_s;
    mgmt_req && !mgmt_we && mgmt_page == PAGE_DIAG && mgmt_addr == CTRL_STATUS_ADDR;
  endsequence
  sequence status_ans_s;
    mgmt_ack && mgmt_ok;
  endsequence

  ack_follows_req_a: assert property (mgmt_req |=> mgmt_ack)
    else $error("request without answer");
  ack_has_cause_a: assert property (mgmt_ack |-> $past(mgmt_req))
    else $error("answer without request");
  ready_accept_a: assert property (mgmt_req && por_q >= SERIAL_READY_CNT + 2
    && gap_q > WRITE_CYCLE_CNT + 2 |=> mgmt_ok) else $error("request refused when ready");
  byte_spacing_a: assert property (mgmt_req |=> !mgmt_req [*8])
    else $error("bytes too close");
  write_gap_a: assert property (mgmt_req |-> gap_q >= WRITE_CYCLE_CNT - 3)
    else $error("request inside write cycle");
  fault_latched_a: assert property (tx_fault && !laser_disable && !$past(laser_disable)
    && !$past(laser_disable, 2) |=> tx_fault) else $error("fault dropped");
  fault_reset_hold_a: assert property ($fell(tx_fault) |-> hold_q >= RESET_HOLD_CYCLES - 2)
    else $error("fault cleared by short disable");
  status_fault_a: assert property (status_rd_s ##1 status_ans_s ##0 $stable(tx_fault)
    |-> mgmt_rdata[FAULT_BIT] == tx_fault) else $error("fault status bit wrong");
  status_lost_a: assert property (status_rd_s ##1 status_ans_s ##0 $stable(rx_signal_lost)
    |-> mgmt_rdata[SIGNAL_LOST_BIT] == rx_signal_lost) else $error("lost status bit wrong");
endmodule

// [testbench/test_optical_module_control_status.sv]
// Testbench: host end and module end joined by the link interface.
// Assumes shortened counts; the bench drives the host user side and module inputs.
module test_optical_module_control_status;
  timeunit 1ns;
  timeprecision 100ps;
  import optmod_pkg::*;
  localparam int unsigned INIT_N = 50;
  localparam int unsigned READY_N = 80;
  localparam int unsigned SER_N = 20;
  localparam int unsigned WR_N = 30;
  localparam int unsigned BYTE_N = 10;
  typedef struct packed {logic ok; logic [7:0] data; logic [7:0] mask;} exp_s;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic laser_fault, signal_ok, monitor_ok, laser_on, init_done, laser_off, fault_reset;
  logic cmd_valid, cmd_write, cmd_page, cmd_last, cmd_ready, rsp_valid, rsp_ok;
  logic fault, signal_lost;
  logic [7:0] cmd_addr, cmd_data, rsp_data;
  logic [7:0] scratch [8];
  int failures = 0;
  int checks = 0;
  int seed = 91862;
  exp_s exp_q [$];

  always #2 clk_i = ~clk_i;

  optmod_link_if link_inst ();
  optmod_module_end #(.INIT_CNT(INIT_N), .DATA_READY_CNT(READY_N), .SERIAL_READY_CNT(SER_N),
    .WRITE_CYCLE_CNT(WR_N)) optmod_module_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .link(link_inst.module_end), .laser_fault_i(laser_fault), .signal_ok_i(signal_ok),
    .monitor_ok_i(monitor_ok), .laser_on_o(laser_on), .init_done_o(init_done));
  optmod_host_end #(.SERIAL_READY_CNT(SER_N), .WRITE_CYCLE_CNT(WR_N), .BYTE_CNT(BYTE_N))
    optmod_host_end_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link_inst.host_end),
    .laser_off_i(laser_off), .fault_reset_i(fault_reset), .cmd_valid_i(cmd_valid),
    .cmd_write_i(cmd_write), .cmd_page_i(cmd_page), .cmd_addr_i(cmd_addr),
    .cmd_data_i(cmd_data), .cmd_last_i(cmd_last), .cmd_ready_o(cmd_ready),
    .rsp_valid_o(rsp_valid), .rsp_ok_o(rsp_ok), .rsp_data_o(rsp_data), .fault_o(fault),
    .signal_lost_o(signal_lost));
  optmod_link_monitor #(.SERIAL_READY_CNT(SER_N), .WRITE_CYCLE_CNT(WR_N)) monitor_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .laser_disable(link_inst.laser_disable),
    .tx_fault(link_inst.tx_fault), .rx_signal_lost(link_inst.rx_signal_lost),
    .mgmt_req(link_inst.mgmt_req), .mgmt_we(link_inst.mgmt_we),
    .mgmt_page(link_inst.mgmt_page), .mgmt_addr(link_inst.mgmt_addr),
    .mgmt_last(link_inst.mgmt_last), .mgmt_ack(link_inst.mgmt_ack),
    .mgmt_ok(link_inst.mgmt_ok), .mgmt_rdata(link_inst.mgmt_rdata));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic check_bit(input logic got, input logic want, input string what);
    checks++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic compare_rsp(input exp_s e);
    checks++;
    if (rsp_ok !== e.ok || (rsp_data & e.mask) !== (e.data & e.mask)) begin
      failures++;
      $display("wrong value at %0t: response %b %h", $time, rsp_ok, rsp_data);
    end
  endtask
  // Entered just after an edge; ready seen here is what the next edge samples
  task automatic send(input logic pg, input logic wr, input logic [7:0] addr,
                      input logic [7:0] data, input logic last, input logic [7:0] want,
                      input logic [7:0] mask);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    exp_q.push_back({1'b1, want, mask});
    cmd_valid = 1'b1;
    cmd_page = pg;
    cmd_write = wr;
    cmd_addr = addr;
    cmd_data = data;
    cmd_last = last;
    tick(1);
    cmd_valid = 1'b0;
  endtask

  // Falling edge sees the response settled, clear of the edge that launches it
  always @(negedge clk_i) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("wrong value at %0t: unexpected response", $time);
      end else begin
        compare_rsp(exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    $display("wrong value at %0t: timeout", $time);
    end_of_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {laser_fault, laser_off, fault_reset, cmd_valid, cmd_write, cmd_page, cmd_last} = 7'h00;
    {signal_ok, monitor_ok, cmd_addr, cmd_data} = 18'h30000;
    tick(4);
    rst_b_i = 1'b1;
    tick(READY_N + 5);
    check_bit(init_done, 1'b1, "init done");
    check_bit(laser_on, 1'b1, "laser on");
    check_bit(signal_lost, 1'b0, "signal lost");
    send(PAGE_ID, 1'b0, 8'h10, 8'h00, 1'b0, UNMAPPED_DATA, 8'hFF);
    send(PAGE_DIAG, 1'b0, CTRL_STATUS_ADDR, 8'h00, 1'b0, 8'h01, 8'hC7);
    send(PAGE_DIAG, 1'b1, CTRL_STATUS_ADDR, 8'h40, 1'b1, 8'h00, 8'h00);
    tick(4);
    check_bit(laser_on, 1'b0, "soft disable");
    send(PAGE_DIAG, 1'b0, CTRL_STATUS_ADDR, 8'h00, 1'b0, 8'h41, 8'hC7);
    send(PAGE_DIAG, 1'b1, CTRL_STATUS_ADDR, 8'h00, 1'b1, 8'h00, 8'h00);
    tick(INIT_N + 5);
    check_bit(laser_on, 1'b1, "soft enable");
    for (int i = 0; i < SCRATCH_DEPTH; i++) begin
      scratch[i] = 8'($random(seed));
      send(PAGE_DIAG, 1'b1, SCRATCH_BASE_ADDR + 8'(i), scratch[i], i == 7, 8'h00, 8'h00);
    end
    for (int i = 0; i < SCRATCH_DEPTH; i++) begin
      send(PAGE_DIAG, 1'b0, SCRATCH_BASE_ADDR + 8'(i), 8'h00, 1'b0, scratch[i], 8'hFF);
    end
    laser_fault = 1'b1;
    tick(1);
    laser_fault = 1'b0;
    tick(3);
    check_bit(fault, 1'b1, "fault out");
    send(PAGE_DIAG, 1'b0, CTRL_STATUS_ADDR, 8'h00, 1'b0, 8'h04, 8'h04);
    laser_off = 1'b1;
    tick(2);
    check_bit(laser_on, 1'b0, "hw disable");
    tick(100);
    laser_off = 1'b0;
    tick(INIT_N + 5);
    check_bit(fault, 1'b1, "fault held after short disable");
    fault_reset = 1'b1;
    tick(1);
    fault_reset = 1'b0;
    tick(RESET_HOLD_CYCLES + INIT_N + 10);
    check_bit(fault, 1'b0, "fault cleared");
    check_bit(laser_on, 1'b1, "laser back");
    laser_off = 1'b1;
    monitor_ok = 1'b0;
    tick(2);
    check_bit(laser_on, 1'b0, "hw disable alone");
    send(PAGE_DIAG, 1'b0, CTRL_STATUS_ADDR, 8'h00, 1'b0, 8'h80, 8'hC7);
    laser_off = 1'b0;
    monitor_ok = 1'b1;
    tick(INIT_N + 5);
    check_bit(laser_on, 1'b1, "hw enable");
    signal_ok = 1'b0;
    tick(3);
    check_bit(signal_lost, 1'b1, "loss out");
    send(PAGE_DIAG, 1'b0, CTRL_STATUS_ADDR, 8'h00, 1'b0, 8'h02, 8'h06);
    signal_ok = 1'b1;
    tick(3);
    check_bit(signal_lost, 1'b0, "loss cleared");
    send(PAGE_DIAG, 1'b0, CTRL_STATUS_ADDR, 8'h00, 1'b0, 8'h00, 8'h06);
    tick(5);
    check_bit(exp_q.size() == 0, 1'b1, "responses missing");
    rst_b_i = 1'b0;
    tick(2);
    check_bit(init_done, 1'b0, "init in reset");
    rst_b_i = 1'b1;
    tick(INIT_N + 5);
    check_bit(init_done, 1'b1, "init again");
    end_of_test();
  end
endmodule
